/* File: hw/code_decode.v */
// code to reference level decoder with registered output
`timescale 1ns/1ps
`default_nettype none
`include "ss_vid_consts.vh"
module code_decode (
  // clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // code in, level out
  input wire [`CODE_W-1:0] code_i,
  output reg [`LVL_W-1:0] level_o
);
  wire [`LVL_W-1:0] inv_code;
  // level in 25 mV units: 0.800 V is 32, code 11110 maps there
  assign inv_code = {3'h0, ~code_i};
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      level_o <= `LVL_OFF;
    end else if (code_i == `CODE_OFF) begin
      level_o <= `LVL_OFF;
    end else begin
      level_o <= `LVL_BASE + inv_code - `LVL_STEP;
    end
  end
endmodule
`default_nettype wire

/* File: hw/soft_start_vid_stepper.v */
// soft-start ramp, hiccup wait and stepped reference sequencer
// Notes on behaviour
// - soft-start timed by 11-bit counter, one count per phase pulse, 2048 cycles
// - ramp target rises linearly from zero to 140% of reference
// - ramp offset term falls linearly from 160 uA to zero
// - during soft-start the target is the lower of reference and ramp
// - code sampled for stepping only at phase-1 cycle start; all-ones shutdown code checked every clock
// - new code acted on only if stable one more full cycle
// - after valid change, step reference 25 mV every two cycles
// - all-ones code shuts down, any other code restarts
// - out of reset, enabled and code not all ones: soft-start at once
// - after overcurrent, outputs off for 2048 cycles then retry
`timescale 1ns/1ps
`default_nettype none
`include "ss_vid_consts.vh"
module soft_start_vid_stepper (
  // clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // pins from outside the clock domain
  input wire [`CODE_W-1:0] voltage_id_code_inputs_i,
  input wire enable_above_thresh_i,
  input wire overcurrent_i,
  // timing enables from the phase clock divider
  input wire phase_pulse_i,
  input wire phase1_start_i,
  // outputs
  output reg [`LVL_W-1:0] reference_level_o,
  output reg [`RAMP_W-1:0] soft_start_ramp_level_o,
  output reg [`OFS_W-1:0] ramp_offset_term_o,
  output reg [`RAMP_W-1:0] regulation_target_o,
  output reg outputs_on_o,
  output reg soft_start_active_o
);
  localparam ST_OFF = 2'h0;
  localparam ST_SS = 2'h1;
  localparam ST_RUN = 2'h2;
  localparam ST_WAIT = 2'h3;

  reg [`CODE_W-1:0] code_m_q, code_s_q;
  reg en_m_q, en_s_q, oc_m_q, oc_s_q;
  reg [1:0] state_q, state_d;
  reg [`SS_CNT_W-1:0] cnt_q, cnt_d;
  reg [`CODE_W-1:0] seen_q;
  reg cand_v_q, step_ph_q;
  reg [`LVL_W-1:0] target_q;
  wire [`LVL_W-1:0] dec_level;
  wire code_off;
  wire accept;
  wire [`LVL_W-1:0] goal;
  wire step_now;
  wire [`RAMP_W-1:0] ramp_full;
  wire [`RAMP_W-1:0] ref_wide;
  wire [`RAMP_W+`SS_CNT_W-1:0] ramp_scaled;
  wire [`RAMP_W+`SS_CNT_W-1:0] ramp_prod;
  wire [`RAMP_W-1:0] ramp_next;
  wire [`SS_CNT_W:0] cnt_left;
  wire [`OFS_W+`SS_CNT_W:0] ofs_prod;
  wire [`OFS_W-1:0] ofs_next;

  // two-flop synchronisers on pins
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      code_m_q <= `CODE_OFF;
      code_s_q <= `CODE_OFF;
      en_m_q <= 1'b0;
      en_s_q <= 1'b0;
      oc_m_q <= 1'b0;
      oc_s_q <= 1'b0;
    end else begin
      code_m_q <= voltage_id_code_inputs_i;
      code_s_q <= code_m_q;
      en_m_q <= enable_above_thresh_i;
      en_s_q <= en_m_q;
      oc_m_q <= overcurrent_i;
      oc_s_q <= oc_m_q;
    end
  end

  code_decode u_dec (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .code_i(seen_q),
    .level_o(dec_level)
  );

  assign code_off = (code_s_q == `CODE_OFF);

  // state sequencing
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_OFF: begin
        cnt_d = {`SS_CNT_W{1'b0}};
        if (en_s_q && !code_off) begin
          state_d = ST_SS;
        end
      end
      ST_SS: begin
        if (phase_pulse_i) begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == `SS_CNT_LAST) begin
            state_d = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        cnt_d = {`SS_CNT_W{1'b0}};
      end
      ST_WAIT: begin
        if (phase_pulse_i) begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == `HICCUP_LAST) begin
            state_d = ST_SS;
            cnt_d = {`SS_CNT_W{1'b0}};
          end
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
    if (!en_s_q || code_off) begin
      state_d = ST_OFF;
      cnt_d = {`SS_CNT_W{1'b0}};
    end else if (oc_s_q && state_q != ST_WAIT && state_q != ST_OFF) begin
      state_d = ST_WAIT;
      cnt_d = {`SS_CNT_W{1'b0}};
    end
  end

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_OFF;
      cnt_q <= {`SS_CNT_W{1'b0}};
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // a code seen twice in a row is taken, and the first step is due at once
  assign accept = phase1_start_i && cand_v_q && (code_s_q == seen_q);
  assign goal = accept ? dec_level : target_q;
  assign step_now = phase1_start_i && (accept || step_ph_q == `STEP_GAP);

  // code change detection and stepping
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      seen_q <= `CODE_OFF;
      cand_v_q <= 1'b0;
      step_ph_q <= 1'b0;
      target_q <= `LVL_OFF;
    end else begin
      if (phase1_start_i) begin
        seen_q <= code_s_q;
        if (code_s_q != seen_q) begin
          cand_v_q <= 1'b1;
        end else if (cand_v_q) begin
          cand_v_q <= 1'b0;
        end
        step_ph_q <= accept ? 1'b0 : ~step_ph_q;
      end
      // old level holds while a new code waits for its second look
      if (!cand_v_q || accept) begin
        target_q <= dec_level;
      end
    end
  end

  // reference stepping, 25 mV every other cycle
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reference_level_o <= `LVL_OFF;
    end else if (state_q == ST_OFF) begin
      reference_level_o <= target_q;
    end else if (step_now) begin
      if (reference_level_o < goal) begin
        reference_level_o <= reference_level_o + `LVL_STEP;
      end else if (reference_level_o > goal) begin
        reference_level_o <= reference_level_o - `LVL_STEP;
      end
    end
  end

  assign ref_wide = {reference_level_o, {(`RAMP_W-`LVL_W){1'b0}}};
  // full ramp is 140% of the reference, below 16 bits for every code
  assign ramp_scaled = {{`SS_CNT_W{1'b0}}, ref_wide}
    * {{`SS_CNT_W{1'b0}}, `RAMP_NUM} / {{`SS_CNT_W{1'b0}}, `RAMP_DEN};
  assign ramp_full = ramp_scaled[`RAMP_W-1:0];
  assign ramp_prod = {{`SS_CNT_W{1'b0}}, ramp_full}
    * {{`RAMP_W{1'b0}}, cnt_q};
  assign ramp_next = ramp_prod[`RAMP_W+`SS_CNT_W-1:`SS_CNT_W];
  // pulses left in the interval, 2048 at the start
  assign cnt_left = {1'b0, ~cnt_q} + {{`SS_CNT_W{1'b0}}, 1'b1};
  assign ofs_prod = {{(`SS_CNT_W+1){1'b0}}, `OFS_FULL}
    * {{`OFS_W{1'b0}}, cnt_left};
  assign ofs_next = ofs_prod[`OFS_W+`SS_CNT_W-1:`SS_CNT_W];

  // ramp, offset and effective target
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      soft_start_ramp_level_o <= {`RAMP_W{1'b0}};
      ramp_offset_term_o <= {`OFS_W{1'b0}};
      regulation_target_o <= {`RAMP_W{1'b0}};
      outputs_on_o <= 1'b0;
      soft_start_active_o <= 1'b0;
    end else begin
      outputs_on_o <= (state_q == ST_SS) || (state_q == ST_RUN);
      soft_start_active_o <= (state_q == ST_SS);
      if (state_q == ST_SS) begin
        soft_start_ramp_level_o <= ramp_next;
        ramp_offset_term_o <= ofs_next;
        if (ramp_next < ref_wide) begin
          regulation_target_o <= ramp_next;
        end else begin
          regulation_target_o <= ref_wide;
        end
      end else if (state_q == ST_RUN) begin
        soft_start_ramp_level_o <= ramp_full;
        ramp_offset_term_o <= {`OFS_W{1'b0}};
        regulation_target_o <= ref_wide;
      end else begin
        soft_start_ramp_level_o <= {`RAMP_W{1'b0}};
        ramp_offset_term_o <= {`OFS_W{1'b0}};
        regulation_target_o <= {`RAMP_W{1'b0}};
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/ss_vid_consts.vh */
// constants for the soft-start and code-stepping sequencer
`ifndef SS_VID_CONSTS_VH
`define SS_VID_CONSTS_VH
`define SS_CNT_W 11
`define SS_CNT_LAST 11'h7FF
`define HICCUP_LAST 11'h7FF
`define CODE_W 5
`define CODE_OFF 5'h1F
`define LVL_W 8
`define LVL_STEP 8'h01
`define LVL_BASE 8'h20
`define LVL_OFF 8'h00
`define RAMP_W 16
`define RAMP_NUM 16'h000E
`define RAMP_DEN 16'h000A
`define OFS_W 8
`define OFS_FULL 8'hA0
`define STEP_GAP 1'h1
`endif

/* File: verification/soft_start_vid_stepper_tb_top.sv */
// self-checking bench for the soft-start and code stepper
`timescale 1ns/1ps
`default_nettype none
module soft_start_vid_stepper_tb_top;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic en = 1'b0;
  logic oc = 1'b0;
  logic [3:0] div = 4'h0;
  logic [4:0] want = 5'h0E;
  wire [4:0] code;
  wire [7:0] lvl, ofs;
  wire [15:0] tgt, rp;
  wire on, ss;
  wire pp = div[1:0] == 2'h0;
  wire p1 = div == 4'h0;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;
  always #2.5 clk_sys_i = ~clk_sys_i;
  always @(negedge clk_sys_i) div <= div + 4'h1;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      conclude();
    end
  end
  vid_host vid_host_inst (.clk_sys_i(clk_sys_i), .want_i(want), .code_o(code));
  soft_start_vid_stepper soft_start_vid_stepper_inst (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .voltage_id_code_inputs_i(code),
    .enable_above_thresh_i(en), .overcurrent_i(oc), .phase_pulse_i(pp),
    .phase1_start_i(p1), .reference_level_o(lvl),
    .soft_start_ramp_level_o(rp), .ramp_offset_term_o(ofs),
    .regulation_target_o(tgt), .outputs_on_o(on), .soft_start_active_o(ss));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // wait for the soft-start flag, counting phase pulses
  task automatic till_ss(input logic v);
    n = 0;
    while (ss !== v) begin
      @(negedge clk_sys_i);
      n += pp;
    end
  endtask
  task automatic t_start;
    till_ss(1'b1);
    chk(ofs, 8'hA0);
    chk(on, 1'b1);
    till_ss(1'b0);
    repeat (2) @(negedge clk_sys_i);
    chk(ofs, 8'h00);
    chk(tgt, 16'h3000);
    chk(rp, 16'h4333);
  endtask
  // four steps up, then four back down
  task automatic t_step;
    logic [4:0] c [2] = '{5'h0A, 5'h0E};
    for (int i = 0; i < 2; i++) begin
      want <= c[i];
      n = 0;
      while (lvl !== 8'h3E - c[i]) begin
        @(negedge clk_sys_i);
        n += p1;
      end
      chk(n >= 7 && n <= 9, 1'b1);
      repeat (40) @(negedge clk_sys_i);
      chk(lvl, 8'h3E - c[i]);
    end
  endtask
  // a code seen at one phase-1 start only is dropped
  task automatic t_glitch;
    logic [7:0] got;
    got = 8'h30;
    @(posedge p1);
    repeat (12) @(negedge clk_sys_i);
    want <= 5'h00;
    for (int i = 0; i < 72; i++) begin
      if (i == 8) want <= 5'h0E;
      @(negedge clk_sys_i);
      if (lvl !== 8'h30) got = lvl;
    end
    chk(got, 8'h30);
  endtask
  task automatic t_off;
    want <= 5'h1F;
    repeat (100) @(negedge clk_sys_i);
    chk(on, 1'b0);
    want <= 5'h0E;
    repeat (100) @(negedge clk_sys_i);
    chk(ss, 1'b1);
    till_ss(1'b0);
  endtask
  task automatic t_hiccup;
    logic w1;
    oc <= 1'b1;
    while (on !== 1'b0) @(negedge clk_sys_i);
    w1 = pp;
    oc <= 1'b0;
    till_ss(1'b1);
    chk(n[15:0] + {15'h0000, w1}, 16'h0800);
  endtask
  initial begin
    repeat (20) @(negedge clk_sys_i);
    rst_i <= 1'b0;
    en <= 1'b1;
    t_start();
    t_step();
    t_glitch();
    t_off();
    t_hiccup();
    conclude();
  end
endmodule
bind soft_start_vid_stepper ss_props ss_props_inst (.clk_sys_i(clk_sys_i),
  .rst_i(rst_i), .overcurrent_i(overcurrent_i), .phase_pulse_i(phase_pulse_i),
  .voltage_id_code_inputs_i(voltage_id_code_inputs_i),
  .reference_level_o(reference_level_o),
  .ramp_offset_term_o(ramp_offset_term_o),
  .soft_start_ramp_level_o(soft_start_ramp_level_o),
  .regulation_target_o(regulation_target_o),
  .outputs_on_o(outputs_on_o), .soft_start_active_o(soft_start_active_o));
`default_nettype wire

/* File: verification/ss_props.sv */
// assertion checker for the soft-start and code stepper
`timescale 1ns/1ps
`default_nettype none
module ss_props (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // inputs watched
  input wire logic overcurrent_i,
  input wire logic phase_pulse_i,
  input wire logic [4:0] voltage_id_code_inputs_i,
  // outputs watched
  input wire logic [7:0] reference_level_o,
  input wire logic [7:0] ramp_offset_term_o,
  input wire logic [15:0] soft_start_ramp_level_o,
  input wire logic [15:0] regulation_target_o,
  input wire logic outputs_on_o,
  input wire logic soft_start_active_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire ss = soft_start_active_o;
  wire on = outputs_on_o;
  wire [7:0] rf = reference_level_o;
  wire [15:0] rp = soft_start_ramp_level_o;
  // phase pulses seen during one soft-start
  // the flag trails the state by one edge, so pulses are counted one late
  logic pp_q;
  logic [11:0] n_q;
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pp_q <= 1'b0;
      n_q <= 12'h000;
    end else begin
      pp_q <= phase_pulse_i;
      n_q <= !ss ? 12'h000 : n_q + {11'h000, pp_q};
    end
  end
  AST_SS_LEN: assert property ($fell(ss) && on |-> n_q == 12'h800)
    else $error("soft-start length");
  AST_SS_INIT: assert property ($rose(ss) |-> rp == 16'h0000
    && ramp_offset_term_o == 8'hA0) else $error("ramp start");
  AST_RAMP_UP: assert property (ss && $past(ss) |-> rp >= $past(rp))
    else $error("ramp fell");
  AST_OFS_DN: assert property (ss && $past(ss) |->
    ramp_offset_term_o <= $past(ramp_offset_term_o)) else $error("offset");
  AST_TGT_MIN: assert property (ss && $past(ss) |->
    regulation_target_o <= rp && regulation_target_o <= {rf, 8'h00})
    else $error("target high");
  AST_STEP: assert property (on && !ss && $past(on) && !$past(ss) |->
    rf == $past(rf) || rf == $past(rf) + 8'h01 || rf == $past(rf) - 8'h01)
    else $error("step size");
  AST_OFF: assert property ($rose(voltage_id_code_inputs_i == 5'h1F) |->
    ##[1:100] !on) else $error("no shutdown");
  AST_OC: assert property ($rose(overcurrent_i) |-> ##[1:8] !on)
    else $error("no overcurrent stop");
endmodule
`default_nettype wire

/* File: verification/vid_host.sv */
// processor side model driving the code pins
`timescale 1ns/1ps
`default_nettype none
module vid_host (
  input wire logic clk_sys_i,
  input wire logic [4:0] want_i,
  output logic [4:0] code_o = 5'h1F
);
  // pins move only off the sampling edge and hold until told again
  always @(negedge clk_sys_i) code_o <= want_i;
endmodule
`default_nettype wire
